// ---- order_completion_sequencer_cfg.svh ----
// Purpose: timing and reset constants for the order completion sequencer
// Assumes: one clock, synchronous reset
// Notes:   included by the package and the design files
`ifndef ORDER_COMPLETION_SEQUENCER_CFG_SVH
`define ORDER_COMPLETION_SEQUENCER_CFG_SVH
`define OCS_CLK_PERIOD_NS    8
`define OCS_NUM_COMPLETIONS  6
`define OCS_TAPE_DIGITS      4
`define OCS_FLAG_RESET       1'b0
`define OCS_STOP_RESET       1'b1
`define OCS_CE_IDX           0
`define OCS_CT_IDX           1
`define OCS_STOP_IDX         2
`define OCS_LOAD_IDX         3
`define OCS_STORE_IDX        4
`define OCS_ARITH_IDX        5
`endif

// ---- order_completion_sequencer_pkg.sv ----
// Purpose: shared types for the order completion sequencer
// Assumes: constants come from the cfg header
// Notes:   types only
`include "order_completion_sequencer_cfg.svh"
package order_completion_sequencer_pkg;
    typedef struct packed {
        logic accum_transfer_order_group;
        logic arithmetic_order_group;
        logic shift_io_order_group;
        logic cond_transfer_order;
        logic transfer_order;
        logic stop_ignore_order;
        logic load_order;
        logic store_order;
        logic memory_order;
    } order_groups_t;

    typedef struct packed {
        logic have_cleared_gated;
        logic have_used_memory;
        logic have_gated_dispatch;
    } mem_checks_t;

    typedef enum logic [1:0] {
        ST_CONTROL = 2'b00,
        ST_OPERATE = 2'b01,
        ST_DONE    = 2'b11,
        ST_TURN    = 2'b10
    } seq_state_t;

    typedef enum logic [1:0] {
        EN_IDLE  = 2'b00,
        EN_STOP  = 2'b01,
        EN_WAIT  = 2'b11,
        EN_END   = 2'b10
    } end_state_t;
endpackage : order_completion_sequencer_pkg

// ---- arith_end_unit.sv ----
// Purpose: stop/end flipflops, end enable and multiplication correction
// Assumes: gate strobes are single level samples on sys_clk_i
// Notes:   correction runs false control for exactly one cycle
`include "order_completion_sequencer_cfg.svh"
`timescale 1ns/100ps
module arith_end_unit (
    input  wire logic sys_clk_i,
    input  wire logic sys_rst_i,
    input  wire logic clk_en_i,
    input  wire logic last_clear_gate_i,
    input  wire logic final_gate_i,
    input  wire logic black_gate_i,
    input  wire logic mult_no_correct_i,
    output logic      stop_ff_o,
    output logic      end_ff_o,
    output logic      end_enable_o,
    output logic      false_ctrl_o,
    output logic      correction_start_o
);
    logic black_q;
    logic end_enable_q;
    logic false_q;
    logic corr_q;
    wire  black_rise = black_gate_i & ~black_q;
    wire  corr_req   = end_enable_q & ~mult_no_correct_i & ~false_q;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            stop_ff_o    <= `OCS_STOP_RESET;
            end_ff_o     <= `OCS_FLAG_RESET;
            black_q      <= `OCS_FLAG_RESET;
            end_enable_q <= `OCS_FLAG_RESET;
            false_q      <= `OCS_FLAG_RESET;
            corr_q       <= `OCS_FLAG_RESET;
        end else if (clk_en_i) begin
            black_q <= black_gate_i;
            if (last_clear_gate_i)
                stop_ff_o <= 1'b0; // RULE17
            else if (false_q)
                stop_ff_o <= 1'b0; // RULE20
            if (false_q)
                end_ff_o <= 1'b0; // RULE20
            else if (!stop_ff_o && final_gate_i)
                end_ff_o <= 1'b1; // RULE17
            if (false_q)
                end_enable_q <= 1'b0;
            else if (end_ff_o && black_rise)
                end_enable_q <= 1'b1; // RULE17
            else if (!end_ff_o)
                end_enable_q <= 1'b0;
            false_q <= corr_req; // RULE20
            corr_q  <= false_q;  // RULE20
        end
    end
    assign end_enable_o       = end_enable_q;
    assign false_ctrl_o       = false_q;
    assign correction_start_o = corr_q;

    sequence corr_seq;
        false_q ##1 (!false_q && corr_q && !end_ff_o);
    endsequence
    corr_flow_a: assert property (@(posedge sys_clk_i) // RULE20
        disable iff (sys_rst_i)
        (clk_en_i && corr_req) ##1 clk_en_i |-> false_q ##0 1'b1)
        else $error("correction did not raise false control");
    corr_seq_a: assert property (@(posedge sys_clk_i) // RULE20
        disable iff (sys_rst_i)
        ($rose(false_q) && clk_en_i) |-> corr_seq)
        else $error("correction sequence broken");
    stop_clear_a: assert property (@(posedge sys_clk_i) // RULE17
        disable iff (sys_rst_i)
        (clk_en_i && last_clear_gate_i) |=> !stop_ff_o)
        else $error("stop flipflop not cleared");
endmodule : arith_end_unit

// ---- completion_decode.sv ----
// Purpose: forms the six completion signals
// Assumes: checks are levels valid while the order is held
// Notes:   purely combinational
`include "order_completion_sequencer_cfg.svh"
`timescale 1ns/100ps
module completion_decode (
    input  order_completion_sequencer_pkg::order_groups_t groups_i,
    input  order_completion_sequencer_pkg::mem_checks_t   checks_i,
    input  wire logic                                   sign_digit_i,
    input  wire logic                                   operate_i,
    input  wire logic                                   end_enable_i,
    input  wire logic                                   tape_end_done_i,
    input  wire logic                                   mult_no_corr_i,
    output logic [`OCS_NUM_COMPLETIONS-1:0]             compl_o
);
    wire used_xfer = checks_i.have_used_memory & checks_i.have_cleared_gated;
    wire used_disp = checks_i.have_used_memory & checks_i.have_gated_dispatch;
    wire arith_any = groups_i.accum_transfer_order_group
                   | groups_i.arithmetic_order_group
                   | groups_i.shift_io_order_group;

    assign compl_o[`OCS_CE_IDX]    = groups_i.cond_transfer_order
                                   & sign_digit_i & operate_i;    // RULE7
    assign compl_o[`OCS_CT_IDX]    = groups_i.transfer_order
                                   & used_disp;                   // RULE8 RULE13
    assign compl_o[`OCS_STOP_IDX]  = groups_i.stop_ignore_order
                                   & used_disp;                   // RULE9 RULE13
    assign compl_o[`OCS_LOAD_IDX]  = groups_i.load_order
                                   & used_xfer;                   // RULE10 RULE13
    assign compl_o[`OCS_STORE_IDX] = groups_i.store_order
                                   & checks_i.have_used_memory;   // RULE11 RULE13
    assign compl_o[`OCS_ARITH_IDX] = arith_any & end_enable_i
                                   & tape_end_done_i
                                   & mult_no_corr_i;              // RULE12 RULE18
endmodule : completion_decode

// ---- order_completion_sequencer.sv ----
// Purpose: interplay control, completion flipflop and operate turnover
// Assumes: memory action cycles reported as level indications
// Notes:   one clock, one clock enable freezes all state
// Overview of operation
// [RULE1] any of three order groups requests shift counter reset
// [RULE2] shift/print/input go condition met when counter reset begins
// [RULE3] transfer and arithmetic orders wait for a full action cycle
// [RULE4] action cycle moves address and numbers into control and third register
// [RULE5] go needs transfer check, memory used and dispatch gate for transfers
// [RULE6] six completion signals, one per order class
// [RULE7] conditional transfer needs sign digit one and operate state
// [RULE8] transfer completion after address reaches control counter
// [RULE9] ignored stop completes after address transfer finishes
// [RULE10] load completes after memory word reaches arithmetic register
// [RULE11] store completes after accumulator word written to memory
// [RULE12] arithmetic completion ends every arithmetic stop order
// [RULE13] single-cycle completions need memory used plus their check; store completion here uses memory used alone
// [RULE14] completion sets completion flipflop which returns to control
// [RULE15] completion flipflop cleared in control; gates operate memory enable
// [RULE16] turnover waits for memory enable gone and memory used dropped
// [RULE17] stop cleared, end set, end enable on next black gate rise
// [RULE18] arithmetic completion is end enable and tape end and no correction
// [RULE19] input order gates four tape digits before completing
// [RULE20] correction raises false control, resets flops, starts subtraction
// [RULE21] memory orders request action cycle; completion clears sync flipflop
// [RULE22] orders without memory turn over as soon as flipflop sets
// [RULE23] reset enable clears shift counter; go starts clear-gate sequences
// [RULE24] all signals are active-high levels on one clock
`include "order_completion_sequencer_cfg.svh"
`timescale 1ns/100ps
module order_completion_sequencer (
    input  wire logic                                   sys_clk_i,
    input  wire logic                                   sys_rst_i,
    input  wire logic                                   clk_en_i,
    input  wire logic                                   order_start_i,
    input  order_completion_sequencer_pkg::order_groups_t groups_i,
    input  order_completion_sequencer_pkg::mem_checks_t   checks_i,
    input  wire logic                                   counter_reset_done_i,
    input  wire logic                                   sign_digit_i,
    input  wire logic                                   input_order_i,
    input  wire logic [`OCS_TAPE_DIGITS-1:0]            tape_digits_i,
    input  wire logic                                   last_clear_gate_i,
    input  wire logic                                   final_gate_i,
    input  wire logic                                   black_gate_i,
    input  wire logic                                   mult_no_correct_i,
    output logic                                        reset_enable_o,
    output logic                                        go_enable_o,
    output logic                                        operate_memory_request,
    output logic                                        addr_to_ctrl_o,
    output logic                                        r2_to_r3_o,
    output logic                                        mem_to_r3_o,
    output logic [`OCS_NUM_COMPLETIONS-1:0]             completion_o,
    output logic                                        completion_ff_o,
    output logic                                        operate_o,
    output logic                                        sync_ff_o,
    output logic                                        tape_gate_o,
    output logic [`OCS_TAPE_DIGITS-1:0]                 accum_digits_o,
    output logic                                        stop_ff_o,
    output logic                                        end_ff_o,
    output logic                                        end_enable_o,
    output logic                                        false_ctrl_o,
    output logic                                        correction_start_o
);
    order_completion_sequencer_pkg::seq_state_t state_q;
    order_completion_sequencer_pkg::seq_state_t state_d;
    logic                          compl_ff_q;
    logic                          sync_q;
    logic                          reset_started_q;
    logic                          tape_busy_q;
    logic                          tape_done_q;
    logic [`OCS_TAPE_DIGITS-1:0]   accum_q;
    logic [`OCS_NUM_COMPLETIONS-1:0] compl_w;
    logic                          end_en_w;

    function automatic logic arith_group(
        input order_completion_sequencer_pkg::order_groups_t g);
        arith_group = g.accum_transfer_order_group
                    | g.arithmetic_order_group
                    | g.shift_io_order_group;
    endfunction : arith_group

    wire operate   = (state_q == order_completion_sequencer_pkg::ST_OPERATE)
                   | (state_q == order_completion_sequencer_pkg::ST_DONE);
    wire in_ctrl   = (state_q == order_completion_sequencer_pkg::ST_CONTROL);
    wire any_arith = operate & arith_group(groups_i);
    wire any_compl = |compl_w;
    wire tape_ok   = ~input_order_i | tape_done_q;

    // reset enable stays up while any arithmetic-unit order is live
    assign reset_enable_o = any_arith; // RULE1 RULE23

    // last go condition, split by order group
    wire go_shift = groups_i.shift_io_order_group
                  & (reset_started_q | reset_enable_o); // RULE2
    wire mem_ok   = checks_i.have_used_memory
                  & checks_i.have_cleared_gated; // RULE3 RULE5
    wire go_arith = groups_i.arithmetic_order_group & mem_ok; // RULE5
    wire go_accum = groups_i.accum_transfer_order_group & mem_ok
                  & checks_i.have_gated_dispatch; // RULE5
    assign go_enable_o = operate & counter_reset_done_i
                       & (go_shift | go_arith | go_accum); // RULE23

    // memory enable interrupted by the completion flipflop
    assign operate_memory_request = operate & groups_i.memory_order
                                  & ~compl_ff_q; // RULE15 RULE21

    // action cycle transfers while memory is requested but not yet reported used
    wire act = operate_memory_request & ~checks_i.have_used_memory;
    assign addr_to_ctrl_o = act & (groups_i.accum_transfer_order_group
                                 | groups_i.transfer_order
                                 | groups_i.stop_ignore_order); // RULE4
    assign r2_to_r3_o  = act & groups_i.accum_transfer_order_group; // RULE4
    assign mem_to_r3_o = act & (groups_i.arithmetic_order_group
                              | groups_i.load_order); // RULE4

    completion_decode u_decode (
        .groups_i        (groups_i),
        .checks_i        (checks_i),
        .sign_digit_i    (sign_digit_i),
        .operate_i       (operate),
        .end_enable_i    (end_en_w),
        .tape_end_done_i (tape_ok),
        .mult_no_corr_i  (mult_no_correct_i),
        .compl_o         (compl_w)
    ); // RULE6

    // rearm stop logic between orders, else end enable stays set
    wire stop_rearm = sys_rst_i | (clk_en_i & ~any_arith);

    arith_end_unit u_arith_end (
        .sys_clk_i          (sys_clk_i),
        .sys_rst_i          (stop_rearm),
        .clk_en_i           (clk_en_i),
        .last_clear_gate_i  (last_clear_gate_i),
        .final_gate_i       (final_gate_i),
        .black_gate_i       (black_gate_i),
        .mult_no_correct_i  (mult_no_correct_i),
        .stop_ff_o          (stop_ff_o),
        .end_ff_o           (end_ff_o),
        .end_enable_o       (end_en_w),
        .false_ctrl_o       (false_ctrl_o),
        .correction_start_o (correction_start_o)
    );
    assign end_enable_o = end_en_w;

    // completion only counts while operating
    assign completion_o = operate ? compl_w
                                  : {`OCS_NUM_COMPLETIONS{1'b0}};

    // turnover waits for memory to let go; non-memory orders never wait
    wire turn_ok = compl_ff_q & ~operate_memory_request
                 & (~groups_i.memory_order
                    | ~checks_i.have_used_memory); // RULE16 RULE22

    always_comb begin
        state_d = state_q;
        case (state_q)
            order_completion_sequencer_pkg::ST_CONTROL: begin
                if (order_start_i)
                    state_d = order_completion_sequencer_pkg::ST_OPERATE;
            end
            order_completion_sequencer_pkg::ST_OPERATE: begin
                if (compl_ff_q)
                    state_d = order_completion_sequencer_pkg::ST_DONE;
            end
            order_completion_sequencer_pkg::ST_DONE: begin
                if (turn_ok)
                    state_d = order_completion_sequencer_pkg::ST_TURN;
            end
            order_completion_sequencer_pkg::ST_TURN: begin
                state_d = order_completion_sequencer_pkg::ST_CONTROL;
            end
            default: state_d = order_completion_sequencer_pkg::ST_CONTROL;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state_q         <= order_completion_sequencer_pkg::ST_CONTROL;
            compl_ff_q      <= `OCS_FLAG_RESET;
            sync_q          <= `OCS_FLAG_RESET;
            reset_started_q <= `OCS_FLAG_RESET;
        end else if (clk_en_i) begin
            state_q <= state_d; // RULE14
            if (operate && any_compl)
                compl_ff_q <= 1'b1; // RULE14
            else if (in_ctrl)
                compl_ff_q <= 1'b0; // RULE15
            if (operate && any_compl)
                sync_q <= 1'b0; // RULE21
            else if (operate_memory_request)
                sync_q <= 1'b1;
            reset_started_q <= any_arith & (reset_started_q | reset_enable_o);
        end
    end

    // tape tail: digits gated after end enable, then tape end released
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            tape_busy_q <= `OCS_FLAG_RESET;
            tape_done_q <= `OCS_FLAG_RESET;
            accum_q     <= {`OCS_TAPE_DIGITS{1'b0}};
        end else if (clk_en_i) begin
            if (!operate) begin
                tape_busy_q <= 1'b0;
                tape_done_q <= 1'b0;
            end else if (input_order_i && end_en_w && !tape_done_q) begin
                tape_busy_q <= ~tape_busy_q;
                tape_done_q <= tape_busy_q; // RULE19
                if (!tape_busy_q)
                    accum_q <= tape_digits_i; // RULE19
            end
        end
    end

    assign completion_ff_o = compl_ff_q;
    assign operate_o       = operate;
    assign sync_ff_o       = sync_q;
    assign tape_gate_o     = tape_busy_q;
    assign accum_digits_o  = accum_q;

    // assertions
    sequence turn_seq;
        compl_ff_q ##1 (state_q == order_completion_sequencer_pkg::ST_DONE);
    endsequence

    reset_req_a: assert property (@(posedge sys_clk_i) // RULE1
        disable iff (sys_rst_i)
        any_arith |-> reset_enable_o)
        else $error("reset enable missing for group order");
    go_wait_a: assert property (@(posedge sys_clk_i) // RULE3
        disable iff (sys_rst_i)
        (go_enable_o && !groups_i.shift_io_order_group)
        |-> checks_i.have_used_memory)
        else $error("go before action cycle done");
    go_accum_a: assert property (@(posedge sys_clk_i) // RULE5
        disable iff (sys_rst_i)
        (go_enable_o && groups_i.accum_transfer_order_group
         && !groups_i.shift_io_order_group) |-> checks_i.have_gated_dispatch)
        else $error("go without dispatch gating");
    cond_xfer_a: assert property (@(posedge sys_clk_i) // RULE7
        disable iff (sys_rst_i)
        completion_o[`OCS_CE_IDX] |-> (sign_digit_i && operate))
        else $error("conditional transfer without sign");
    compl_set_a: assert property (@(posedge sys_clk_i) // RULE14
        disable iff (sys_rst_i)
        (clk_en_i && operate && any_compl && !compl_ff_q) ##1 clk_en_i
        |-> turn_seq)
        else $error("completion flipflop not set");
    mem_gate_a: assert property (@(posedge sys_clk_i) // RULE15
        disable iff (sys_rst_i)
        compl_ff_q |-> !operate_memory_request)
        else $error("memory request with completion set");
    turn_wait_a: assert property (@(posedge sys_clk_i) // RULE16
        disable iff (sys_rst_i)
        (state_q == order_completion_sequencer_pkg::ST_TURN)
        |-> $past(turn_ok))
        else $error("turnover before memory released");
    ctrl_clear_a: assert property (@(posedge sys_clk_i) // RULE15
        disable iff (sys_rst_i)
        (clk_en_i && in_ctrl && !any_compl) |=> !compl_ff_q)
        else $error("completion flipflop not cleared");
    arith_and_a: assert property (@(posedge sys_clk_i) // RULE18
        disable iff (sys_rst_i)
        completion_o[`OCS_ARITH_IDX]
        |-> (end_en_w && tape_ok && mult_no_correct_i))
        else $error("arithmetic completion without inputs");
    sync_clr_a: assert property (@(posedge sys_clk_i) // RULE21
        disable iff (sys_rst_i)
        (clk_en_i && operate && any_compl) |=> !sync_q)
        else $error("sync flipflop not cleared");
endmodule : order_completion_sequencer

// ---- mem_stop_model.sv ----
// Purpose: memory control and shift counter stand-in
// Assumes: answers as levels on sys_clk_i, delay picked by slow_i
// Notes:   checks drop one clock after the request drops, never left stale
`timescale 1ns/100ps
module mem_stop_model (
    input  wire logic       sys_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       slow_i,
    input  wire logic       mem_req_i,
    input  wire logic       ctr_reset_i,
    output logic [2:0]      checks_o,
    output logic            ctr_done_o
);
    logic [2:0] wait_q;
    logic [1:0] ctr_q;
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || !mem_req_i) wait_q <= 3'h0;
        else if (wait_q != 3'h7) wait_q <= wait_q + 3'h1;
        if (sys_rst_i || !ctr_reset_i) ctr_q <= 2'h0;
        else if (ctr_q != 2'h3) ctr_q <= ctr_q + 2'h1;
    end
    // slow memory lets the wait states show
    wire logic used_w = wait_q >= (slow_i ? 3'h5 : 3'h1);
    assign checks_o   = {3{used_w}};
    assign ctr_done_o = ctr_q == 2'h3;
endmodule : mem_stop_model

// ---- order_completion_sequencer_tb.sv ----
// Purpose: self-checking bench for the order completion sequencer
// Assumes: mem_stop_model stands for memory and shift counter
// Notes:   orders run as task calls with expected values
`timescale 1ns/100ps
module order_completion_sequencer_tb;
    localparam logic [8:0] STORE = 9'h003;
    localparam logic [8:0] COND  = 9'h020;
    localparam logic [8:0] SHIFT = 9'h100 >> 2;
    localparam logic [8:0] ARITH = 9'h081;
    logic       sys_clk_i = 0, sys_rst_i = 1, start = 0, sign = 0;
    logic       lcg = 0, fg = 0, bg = 0, nocorr = 1, slow = 0;
    logic [8:0] grp = '0;
    logic [2:0] checks;
    logic [5:0] comp;
    logic       ctr_done, rst_en, go_en, mem_req, comp_ff, operate;
    logic       sync_ff, stop_ff, end_ff, end_en, false_ctrl, corr_go;
    logic       inp = 0, tape_gate, a2c, r2r3, m2r3;
    logic [3:0] acc;
    int         mismatches = 0, n_checks = 0, cycles = 0;

    always #4 sys_clk_i = ~sys_clk_i;

    order_completion_sequencer DUT (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1),
        .order_start_i(start), .groups_i(grp), .checks_i(checks),
        .counter_reset_done_i(ctr_done), .sign_digit_i(sign),
        .input_order_i(inp), .tape_digits_i(4'h5),
        .last_clear_gate_i(lcg), .final_gate_i(fg), .black_gate_i(bg),
        .mult_no_correct_i(nocorr), .reset_enable_o(rst_en),
        .go_enable_o(go_en), .operate_memory_request(mem_req),
        .addr_to_ctrl_o(a2c), .r2_to_r3_o(r2r3), .mem_to_r3_o(m2r3),
        .completion_o(comp), .completion_ff_o(comp_ff),
        .operate_o(operate), .sync_ff_o(sync_ff), .tape_gate_o(tape_gate),
        .accum_digits_o(acc), .stop_ff_o(stop_ff), .end_ff_o(end_ff),
        .end_enable_o(end_en), .false_ctrl_o(false_ctrl),
        .correction_start_o(corr_go));
    mem_stop_model far_end (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .slow_i(slow),
        .mem_req_i(mem_req), .ctr_reset_i(rst_en), .checks_o(checks),
        .ctr_done_o(ctr_done));

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    always @(posedge sys_clk_i) begin
        cycles++;
        // all tests need a few hundred cycles at most
        if (cycles == 3000) begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic chk(input string what, input logic [5:0] exp,
                       input logic [5:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : tick

    task automatic run(input logic [8:0] g, input logic s, input logic sg);
        @(posedge sys_clk_i);
        grp   <= g;
        slow  <= s;
        sign  <= sg;
        start <= 1'b1;
        @(posedge sys_clk_i);
        start <= 1'b0;
        #1;
    endtask : run

    task automatic wait_bit(input int idx, input int lim);
        for (int i = 0; i < lim && comp[idx] !== 1'b1; i++) tick(1);
    endtask : wait_bit

    task automatic wait_ctrl;
        for (int i = 0; i < 12 && {operate, comp_ff} !== 2'b00; i++) tick(1);
        chk("back in control", 6'h0, {operate, comp_ff});
    endtask : wait_ctrl

    task automatic gate_seq;
        @(posedge sys_clk_i);
        lcg <= 1'b1;
        @(posedge sys_clk_i);
        lcg <= 1'b0;
        fg  <= 1'b1;
        @(posedge sys_clk_i);
        fg <= 1'b0;
        bg <= 1'b1;
        @(posedge sys_clk_i);
        bg <= 1'b0;
        #1;
        for (int i = 0; i < 4 && end_en !== 1'b1; i++) tick(1);
    endtask : gate_seq

    task automatic rst_dut;
        @(posedge sys_clk_i);
        sys_rst_i <= 1'b1;
        nocorr    <= 1'b1;
        @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        #1;
    endtask : rst_dut

    initial begin
        repeat (10) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        #1;
        chk("flops after reset", 6'h1, {comp_ff, stop_ff});
        run(STORE, 1'b1, 1'b0);
        chk("memory request", 6'h1, mem_req);
        wait_bit(4, 20);
        chk("store completion", 6'h10, comp);
        tick(1);
        chk("flop set request gone", 6'h2, {comp_ff, mem_req});
        chk("sync flop", 6'h0, sync_ff);
        wait_ctrl();
        $display("test store done");
        run(COND, 1'b0, 1'b1);
        wait_bit(0, 10);
        chk("transfer condition", 6'h01, comp);
        wait_ctrl();
        run(COND, 1'b0, 1'b0);
        tick(8);
        chk("no transfer", 6'h1, {comp[0], operate});
        rst_dut();
        $display("test conditional transfer done");
        run(SHIFT, 1'b0, 1'b0);
        chk("counter reset request", 6'h2, {rst_en, go_en});
        tick(4);
        chk("go for shift", 6'h1, go_en);
        gate_seq();
        chk("stop end enable", 6'h3, {stop_ff, end_ff, end_en});
        chk("arith completion", 6'h20, comp);
        wait_ctrl();
        $display("test shift done");
        @(posedge sys_clk_i);
        inp <= 1'b1;
        run(SHIFT, 1'b0, 1'b0);
        tick(4);
        gate_seq();
        chk("tape end holds", 6'h00, comp);
        tick(1);
        chk("tape digits", 6'h15, {tape_gate, acc});
        tick(1);
        chk("input completion", 6'h20, comp);
        wait_ctrl();
        @(posedge sys_clk_i);
        inp <= 1'b0;
        $display("test input tail done");
        run(ARITH, 1'b1, 1'b0);
        chk("action cycle moves", 6'h1, {a2c, r2r3, m2r3});
        tick(3);
        chk("go held for memory", 6'h0, go_en);
        for (int i = 0; i < 20 && go_en !== 1'b1; i++) tick(1);
        chk("go after memory", 6'h1, go_en);
        @(posedge sys_clk_i);
        nocorr <= 1'b0;
        gate_seq();
        for (int i = 0; i < 3 && false_ctrl !== 1'b1; i++) tick(1);
        chk("false control", 6'h1, {comp[5], false_ctrl});
        tick(1);
        chk("correction start", 6'h1, {false_ctrl, corr_go});
        rst_dut();
        $display("test correction done");
        print_verdict();
    end
endmodule : order_completion_sequencer_tb
